// *** samd_pkg.sv ***
// Constants for the segment and addressing-form decoder.
// Assumes fields are taken straight from the fetched instruction bytes.
package samd_pkg;

  // ****************************************************************
  // Segment register codes
  // ****************************************************************
  localparam logic [2:0] SEG_EXTRA = 3'h0;
  localparam logic [2:0] SEG_CODE  = 3'h1;
  localparam logic [2:0] SEG_STACK = 3'h2;
  localparam logic [2:0] SEG_DATA  = 3'h3;
  localparam logic [2:0] SEG_AUX1  = 3'h4;
  localparam logic [2:0] SEG_AUX2  = 3'h5;

  // Kind of segment selector field carried by the instruction
  localparam logic [1:0] SEGF_NONE   = 2'h0;
  localparam logic [1:0] SEGF_NARROW = 2'h1;
  localparam logic [1:0] SEGF_WIDE   = 2'h2;

  // ****************************************************************
  // Field positions in the operand-locator and scaled-index bytes
  // ****************************************************************
  localparam int FORM_HI = 7;
  localparam int FORM_LO = 6;
  localparam int MID_HI  = 5;
  localparam int MID_LO  = 3;
  localparam int LOC_HI  = 2;
  localparam int LOC_LO  = 0;

  // Address form codes
  localparam logic [1:0] FORM_NODISP = 2'h0;
  localparam logic [1:0] FORM_DISP8  = 2'h1;
  localparam logic [1:0] FORM_DISPW  = 2'h2;
  localparam logic [1:0] FORM_REG    = 2'h3;

  // Special locator and index codes
  localparam logic [2:0] LOC_SIB      = 3'h4;
  localparam logic [2:0] LOC_DIRECT16 = 3'h6;
  localparam logic [2:0] LOC_DIRECT32 = 3'h5;
  localparam logic [2:0] IDX_NONE     = 3'h4;
  localparam logic [1:0] SCALE_ONE    = 2'h0;

  // ****************************************************************
  // Register numbers
  // ****************************************************************
  localparam logic [2:0] GPR3 = 3'h3;
  localparam logic [2:0] GPR4 = 3'h4;
  localparam logic [2:0] GPR5 = 3'h5;
  localparam logic [2:0] GPR6 = 3'h6;
  localparam logic [2:0] GPR7 = 3'h7;

  // Operand size and displacement size codes
  typedef enum logic [1:0] {
    SAMD_SZ_BYTE  = 2'h0,
    SAMD_SZ_WORD  = 2'h1,
    SAMD_SZ_DWORD = 2'h2
  } samd_size_e;

  typedef enum logic [1:0] {
    SAMD_DISP_NONE  = 2'h0,
    SAMD_DISP_BYTE  = 2'h1,
    SAMD_DISP_WORD  = 2'h2,
    SAMD_DISP_DWORD = 2'h3
  } samd_disp_e;

endpackage

// *** samd_decode.sv ***
// Segment selector and operand addressing-form decoder, one cycle latency.
// Assumes inputs come from fetch logic on the same clock, held per request.
`timescale 1ns/1ps

// Behaviour
// - narrow selector maps to four segments
// - wide selector adds two auxiliary segments
// - implied-form instructions take no addressing bytes
// - locator byte follows opcode, optional index byte
// - index byte only for 32-bit, locator 100
// - index byte fields define 32-bit form
// - middle bits are opcode extension or register
// - address size picks 16 or 32-bit table
// - 16-bit addressing uses 16-bit components only
// - form 00 16-bit base/index table, segments
// - forms 01/10 add displacement, 110 is gpr5
// - register operand in 16-bit data mode
// - register operand in 32-bit data mode
// - width select gives byte or full size
// - sizes from code default, toggled by prefix
// - 32-bit direct displacement and gpr5 forms
// - scale factors; no index needs scale 00
module samd_decode (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Request from fetch
  input  wire logic       in_valid,
  input  wire logic       implied_form,
  input  wire logic [7:0] locator_byte,
  input  wire logic [7:0] scaled_index_byte,
  input  wire logic       width_select,
  input  wire logic       mid_is_register,
  input  wire logic [1:0] seg_field_kind,
  input  wire logic [2:0] seg_field,
  // Size state
  input  wire logic       code_seg_default,
  input  wire logic       opsize_override,
  input  wire logic       addrsize_override,
  // Decode result
  output logic            out_valid,
  output logic            data32,
  output logic            addr32,
  output logic            locator_used,
  output logic            sib_expected,
  output logic            seg_valid,
  output logic [2:0]      seg_id,
  output logic            invalid_op,
  output logic            reg_operand,
  output logic [2:0]      op_reg_num,
  output logic            op_reg_high,
  output logic [1:0]      op_size,
  output logic            mid_reg_valid,
  output logic            opcode_ext_valid,
  output logic [2:0]      mid_bits,
  output logic            base_valid,
  output logic [2:0]      base_reg,
  output logic            index_valid,
  output logic [2:0]      index_reg,
  output logic [1:0]      scale_bits,
  output logic [1:0]      disp_size,
  output logic [2:0]      ea_seg,
  output logic            ea_undefined
);

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  logic [1:0] form;
  logic [2:0] mid;
  logic [2:0] loc;
  logic [1:0] sc;
  logic [2:0] idx;
  logic [2:0] bas;
  logic       data32_next;
  logic       addr32_next;
  assign form = locator_byte[samd_pkg::FORM_HI:samd_pkg::FORM_LO];
  assign mid  = locator_byte[samd_pkg::MID_HI:samd_pkg::MID_LO];
  assign loc  = locator_byte[samd_pkg::LOC_HI:samd_pkg::LOC_LO];
  assign sc   = scaled_index_byte[samd_pkg::FORM_HI:samd_pkg::FORM_LO];
  assign idx  = scaled_index_byte[samd_pkg::MID_HI:samd_pkg::MID_LO];
  assign bas  = scaled_index_byte[samd_pkg::LOC_HI:samd_pkg::LOC_LO];

  // Effective sizes from code default and prefixes
  assign data32_next = code_seg_default ^ opsize_override;
  assign addr32_next = code_seg_default ^ addrsize_override;

  // ****************************************************************
  // Next-value decode
  // ****************************************************************
  logic       seg_valid_next;
  logic [2:0] seg_id_next;
  logic       invalid_next;
  logic       loc_used_next;
  logic       sib_next;
  logic       reg_op_next;
  logic [2:0] reg_num_next;
  logic       reg_high_next;
  logic [1:0] size_next;
  logic       base_v_next;
  logic [2:0] base_next;
  logic       idx_v_next;
  logic [2:0] idx_next;
  logic [1:0] scale_next;
  logic [1:0] disp_next;
  logic [2:0] ea_seg_next;
  logic       undef_next;

  // Segment selector decode
  always_comb begin
    seg_valid_next = 1'b0;
    seg_id_next    = samd_pkg::SEG_EXTRA;
    invalid_next   = 1'b0;
    if (seg_field_kind == samd_pkg::SEGF_NARROW) begin
      seg_valid_next = 1'b1;
      seg_id_next    = {1'b0, seg_field[1:0]};
    end else if (seg_field_kind == samd_pkg::SEGF_WIDE) begin
      if (seg_field > samd_pkg::SEG_AUX2) begin
        invalid_next = 1'b1;
      end else begin
        seg_valid_next = 1'b1;
        seg_id_next    = seg_field;
      end
    end
  end

  // Operand-locator and scaled-index decode
  always_comb begin
    loc_used_next = ~implied_form;
    sib_next      = 1'b0;
    reg_op_next   = 1'b0;
    reg_num_next  = 3'h0;
    reg_high_next = 1'b0;
    size_next     = samd_pkg::SAMD_SZ_BYTE;
    base_v_next   = 1'b0;
    base_next     = 3'h0;
    idx_v_next    = 1'b0;
    idx_next      = 3'h0;
    scale_next    = samd_pkg::SCALE_ONE;
    disp_next     = samd_pkg::SAMD_DISP_NONE;
    ea_seg_next   = samd_pkg::SEG_DATA;
    undef_next    = 1'b0;
    if (!implied_form) begin
      if (form == samd_pkg::FORM_REG) begin
        // Register operand, byte or full size
        reg_op_next = 1'b1;
        if (!width_select) begin
          reg_num_next  = {1'b0, loc[1:0]};
          reg_high_next = loc[2];
        end else begin
          reg_num_next = loc;
          size_next    = data32_next ? samd_pkg::SAMD_SZ_DWORD
                                     : samd_pkg::SAMD_SZ_WORD;
        end
      end else if (!addr32_next) begin
        // 16-bit table
        base_v_next = 1'b1;
        unique case (loc)
          3'h0: begin
            base_next = samd_pkg::GPR3;
            idx_next  = samd_pkg::GPR6;
          end
          3'h1: begin
            base_next = samd_pkg::GPR3;
            idx_next  = samd_pkg::GPR7;
          end
          3'h2: begin
            base_next = samd_pkg::GPR5;
            idx_next  = samd_pkg::GPR6;
          end
          3'h3: begin
            base_next = samd_pkg::GPR5;
            idx_next  = samd_pkg::GPR7;
          end
          3'h4: base_next = samd_pkg::GPR6;
          3'h5: base_next = samd_pkg::GPR7;
          3'h6: base_next = samd_pkg::GPR5;
          3'h7: base_next = samd_pkg::GPR3;
        endcase
        idx_v_next = ~loc[2];
        if (form == samd_pkg::FORM_NODISP &&
            loc == samd_pkg::LOC_DIRECT16) begin
          base_v_next = 1'b0;
          disp_next   = samd_pkg::SAMD_DISP_WORD;
        end else if (base_next == samd_pkg::GPR5) begin
          ea_seg_next = samd_pkg::SEG_STACK;
        end
        if (form == samd_pkg::FORM_DISP8)
          disp_next = samd_pkg::SAMD_DISP_BYTE;
        if (form == samd_pkg::FORM_DISPW)
          disp_next = samd_pkg::SAMD_DISP_WORD;
      end else begin
        // 32-bit forms
        base_v_next = 1'b1;
        base_next   = loc;
        if (loc == samd_pkg::LOC_SIB) begin
          sib_next   = 1'b1;
          base_next  = bas;
          idx_v_next = (idx != samd_pkg::IDX_NONE);
          idx_next   = idx;
          scale_next = sc;
          undef_next = (idx == samd_pkg::IDX_NONE) &&
                       (sc != samd_pkg::SCALE_ONE);
        end
        if (form == samd_pkg::FORM_NODISP &&
            base_next == samd_pkg::LOC_DIRECT32) begin
          base_v_next = 1'b0;
          disp_next   = samd_pkg::SAMD_DISP_DWORD;
        end else if (base_next == samd_pkg::GPR5 ||
                     (sib_next && base_next == samd_pkg::GPR4)) begin
          ea_seg_next = samd_pkg::SEG_STACK;
        end
        if (form == samd_pkg::FORM_DISP8)
          disp_next = samd_pkg::SAMD_DISP_BYTE;
        if (form == samd_pkg::FORM_DISPW)
          disp_next = samd_pkg::SAMD_DISP_DWORD;
      end
    end
  end

  // ****************************************************************
  // Result registers
  // ****************************************************************

  // Request handshake and size state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      data32    <= 1'b0;
      addr32    <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        data32 <= data32_next;
        addr32 <= addr32_next;
      end
    end
  end

  // Decoded fields, held until the next request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      locator_used     <= 1'b0;
      sib_expected     <= 1'b0;
      seg_valid        <= 1'b0;
      seg_id           <= samd_pkg::SEG_EXTRA;
      invalid_op       <= 1'b0;
      reg_operand      <= 1'b0;
      op_reg_num       <= 3'h0;
      op_reg_high      <= 1'b0;
      op_size          <= samd_pkg::SAMD_SZ_BYTE;
      mid_reg_valid    <= 1'b0;
      opcode_ext_valid <= 1'b0;
      mid_bits         <= 3'h0;
      base_valid       <= 1'b0;
      base_reg         <= 3'h0;
      index_valid      <= 1'b0;
      index_reg        <= 3'h0;
      scale_bits       <= samd_pkg::SCALE_ONE;
      disp_size        <= samd_pkg::SAMD_DISP_NONE;
      ea_seg           <= samd_pkg::SEG_DATA;
      ea_undefined     <= 1'b0;
    end else if (in_valid) begin
      locator_used     <= loc_used_next;
      sib_expected     <= sib_next;
      seg_valid        <= seg_valid_next;
      seg_id           <= seg_id_next;
      invalid_op       <= invalid_next;
      reg_operand      <= reg_op_next;
      op_reg_num       <= reg_num_next;
      op_reg_high      <= reg_high_next;
      op_size          <= size_next;
      mid_reg_valid    <= loc_used_next & mid_is_register;
      opcode_ext_valid <= loc_used_next & ~mid_is_register;
      mid_bits         <= loc_used_next ? mid : 3'h0;
      base_valid       <= base_v_next;
      base_reg         <= base_next;
      index_valid      <= idx_v_next;
      index_reg        <= idx_next;
      scale_bits       <= scale_next;
      disp_size        <= disp_next;
      ea_seg           <= ea_seg_next;
      ea_undefined     <= undef_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_mem_req;
    in_valid && !implied_form && form != samd_pkg::FORM_REG;
  endsequence
  sequence s_sib_req;
    s_mem_req ##0 addr32_next && loc == samd_pkg::LOC_SIB;
  endsequence

  result_latency_a: assert property (in_valid |=> out_valid ##1
    (out_valid == $past(in_valid)))
    else $error("result valid not one cycle after request");
  narrow_seg_map_a: assert property (
    in_valid && seg_field_kind == samd_pkg::SEGF_NARROW |=>
    seg_valid && seg_id == {1'b0, $past(seg_field[1:0])})
    else $error("narrow segment selector misdecoded");
  wide_seg_map_a: assert property (
    in_valid && seg_field_kind == samd_pkg::SEGF_WIDE &&
    seg_field <= samd_pkg::SEG_AUX2 |=> seg_valid && !invalid_op &&
    seg_id == $past(seg_field))
    else $error("wide segment selector misdecoded");
  reserved_seg_a: assert property (
    in_valid && seg_field_kind == samd_pkg::SEGF_WIDE &&
    seg_field > samd_pkg::SEG_AUX2 |=> invalid_op && !seg_valid)
    else $error("reserved segment selector not flagged");
  implied_form_a: assert property (in_valid && implied_form |=>
    !locator_used && !sib_expected && !base_valid && !reg_operand)
    else $error("implied form decoded addressing bytes");
  sib_present_a: assert property (s_sib_req |=> sib_expected)
    else $error("index byte not expected");
  sib_absent_a: assert property (
    in_valid && !(addr32_next && loc == samd_pkg::LOC_SIB &&
    form != samd_pkg::FORM_REG && !implied_form) |=> !sib_expected)
    else $error("index byte expected wrongly");
  direct16_a: assert property (
    s_mem_req ##0 !addr32_next && form == samd_pkg::FORM_NODISP &&
    loc == samd_pkg::LOC_DIRECT16 |=> !base_valid &&
    disp_size == samd_pkg::SAMD_DISP_WORD && ea_seg == samd_pkg::SEG_DATA)
    else $error("16-bit direct form misdecoded");
  gpr5_disp16_a: assert property (
    s_mem_req ##0 !addr32_next && form != samd_pkg::FORM_NODISP &&
    loc == samd_pkg::LOC_DIRECT16 |=> base_valid && !index_valid &&
    base_reg == samd_pkg::GPR5 && ea_seg == samd_pkg::SEG_STACK)
    else $error("16-bit gpr5 displacement form misdecoded");
  byte_reg_a: assert property (
    in_valid && !implied_form && form == samd_pkg::FORM_REG &&
    !width_select |=> reg_operand && op_size == samd_pkg::SAMD_SZ_BYTE &&
    op_reg_num == {1'b0, $past(loc[1:0])} && op_reg_high == $past(loc[2]))
    else $error("byte register operand misdecoded");
  size_override_a: assert property (in_valid |=>
    data32 == $past(code_seg_default ^ opsize_override) &&
    addr32 == $past(code_seg_default ^ addrsize_override))
    else $error("operand or address size override wrong");
  no_index_scale_a: assert property (
    s_sib_req ##0 idx == samd_pkg::IDX_NONE |=> !index_valid &&
    ea_undefined == ($past(sc) != samd_pkg::SCALE_ONE))
    else $error("no-index scale check wrong");

endmodule

// *** samd_result_sink.sv ***
// Partner model: address-generation side that consumes decode results.
// Assumes it shares the decoder clock and synchronous active-low reset.
`timescale 1ns/1ps

module samd_result_sink (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Decode results
  input  wire logic        out_valid,
  input  wire logic        locator_used,
  // Tally of memory or register operands taken
  output logic      [15:0] taken_count
);
  // Counts results whose locator byte was consumed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      taken_count <= 16'h0000;
    end else if (out_valid && locator_used) begin
      taken_count <= taken_count + 16'h0001;
    end
  end
endmodule

// *** test_segment_and_address_mode_decode.sv ***
// Self-checking bench for the segment and addressing-form decoder.
// Assumes the decoder answers one edge after each taken request.
`timescale 1ns/1ps

module test_segment_and_address_mode_decode;
  // ****************************************************************
  // Stimulus rows
  // ****************************************************************
  typedef struct packed {
    logic [4:0] ctl;   // Width, mid role, default, op and addr prefixes
    logic [1:0] kind;
    logic [2:0] seg;
    logic [7:0] loc;
    logic [7:0] sib;
    logic       sibx;
    logic       segv;
    logic [2:0] segid;
    logic       inv;
    logic       regop;
    logic [2:0] rnum;
    logic       rhi;
    logic [1:0] rsz;
    logic       bv;
    logic [2:0] b;
    logic       iv;
    logic [2:0] i;
    logic [1:0] sc;
    logic [1:0] disp;
    logic [2:0] eseg;
  } samd_tb_row_s;

  localparam int N = 16;
  samd_tb_row_s rows [N] = '{
    '{5'h18,2'h1,3'h0,8'h08,8'h00,1'b0,1'b1,3'h0,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b1,3'h3,1'b1,3'h6,2'h0,2'h0,3'h3},
    '{5'h10,2'h1,3'h1,8'h12,8'h00,1'b0,1'b1,3'h1,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b1,3'h5,1'b1,3'h6,2'h0,2'h0,3'h2},
    '{5'h18,2'h1,3'h2,8'h06,8'h00,1'b0,1'b1,3'h2,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b0,3'h0,1'b0,3'h0,2'h0,2'h2,3'h3},
    '{5'h10,2'h1,3'h3,8'h7e,8'h00,1'b0,1'b1,3'h3,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b1,3'h5,1'b0,3'h0,2'h0,2'h1,3'h2},
    '{5'h18,2'h2,3'h4,8'ha5,8'h00,1'b0,1'b1,3'h4,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b1,3'h7,1'b0,3'h0,2'h0,2'h2,3'h3},
    '{5'h10,2'h2,3'h5,8'h07,8'h00,1'b0,1'b1,3'h5,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b1,3'h3,1'b0,3'h0,2'h0,2'h0,3'h3},
    '{5'h10,2'h2,3'h6,8'h04,8'h00,1'b0,1'b0,3'h0,1'b1,
      1'b0,3'h0,1'b0,2'h0,1'b1,3'h6,1'b0,3'h0,2'h0,2'h0,3'h3},
    '{5'h11,2'h2,3'h7,8'h05,8'hff,1'b0,1'b0,3'h0,1'b1,
      1'b0,3'h0,1'b0,2'h0,1'b0,3'h0,1'b0,3'h0,2'h0,2'h3,3'h3},
    '{5'h14,2'h2,3'h0,8'h45,8'h00,1'b0,1'b1,3'h0,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b1,3'h5,1'b0,3'h0,2'h0,2'h1,3'h2},
    '{5'h1c,2'h0,3'h2,8'h04,8'h88,1'b1,1'b0,3'h0,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b1,3'h0,1'b1,3'h1,2'h2,2'h0,3'h3},
    '{5'h11,2'h3,3'h6,8'h84,8'h24,1'b1,1'b0,3'h0,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b1,3'h4,1'b0,3'h0,2'h0,2'h3,3'h2},
    '{5'h14,2'h0,3'h0,8'h04,8'hf5,1'b1,1'b0,3'h0,1'b0,
      1'b0,3'h0,1'b0,2'h0,1'b0,3'h0,1'b1,3'h6,2'h3,2'h3,3'h3},
    '{5'h08,2'h1,3'h2,8'hc5,8'h00,1'b0,1'b1,3'h2,1'b0,
      1'b1,3'h1,1'b1,2'h0,1'b0,3'h0,1'b0,3'h0,2'h0,2'h0,3'h0},
    '{5'h10,2'h1,3'h1,8'hec,8'h00,1'b0,1'b1,3'h1,1'b0,
      1'b1,3'h4,1'b0,2'h1,1'b0,3'h0,1'b0,3'h0,2'h0,2'h0,3'h0},
    '{5'h12,2'h0,3'h0,8'hc7,8'h00,1'b0,1'b0,3'h0,1'b0,
      1'b1,3'h7,1'b0,2'h2,1'b0,3'h0,1'b0,3'h0,2'h0,2'h0,3'h0},
    '{5'h04,2'h0,3'h0,8'hdc,8'h00,1'b0,1'b0,3'h0,1'b0,
      1'b1,3'h0,1'b1,2'h0,1'b0,3'h0,1'b0,3'h0,2'h0,2'h0,3'h0}};

  // Design inputs
  logic       clk, resetn, in_valid, implied_form, width_select;
  logic       mid_is_register, code_seg_default;
  logic       opsize_override, addrsize_override;
  logic [7:0] locator_byte, scaled_index_byte;
  logic [1:0] seg_field_kind;
  logic [2:0] seg_field;
  // Design outputs
  logic       out_valid, data32, addr32, locator_used, sib_expected;
  logic       seg_valid, invalid_op, reg_operand, op_reg_high;
  logic       mid_reg_valid, opcode_ext_valid, base_valid, index_valid;
  logic       ea_undefined;
  logic [2:0] seg_id, op_reg_num, mid_bits, base_reg, index_reg, ea_seg;
  logic [1:0] op_size, scale_bits, disp_size;
  logic [15:0] taken_count;
  int         err_count, checked, cycle_count;
  samd_tb_row_s t;

  samd_decode samd_decode_i (.clk(clk), .resetn(resetn),
    .in_valid(in_valid), .implied_form(implied_form),
    .locator_byte(locator_byte), .scaled_index_byte(scaled_index_byte),
    .width_select(width_select), .mid_is_register(mid_is_register),
    .seg_field_kind(seg_field_kind), .seg_field(seg_field),
    .code_seg_default(code_seg_default), .opsize_override(opsize_override),
    .addrsize_override(addrsize_override), .out_valid(out_valid),
    .data32(data32), .addr32(addr32), .locator_used(locator_used),
    .sib_expected(sib_expected), .seg_valid(seg_valid), .seg_id(seg_id),
    .invalid_op(invalid_op), .reg_operand(reg_operand),
    .op_reg_num(op_reg_num), .op_reg_high(op_reg_high), .op_size(op_size),
    .mid_reg_valid(mid_reg_valid), .opcode_ext_valid(opcode_ext_valid),
    .mid_bits(mid_bits), .base_valid(base_valid), .base_reg(base_reg),
    .index_valid(index_valid), .index_reg(index_reg),
    .scale_bits(scale_bits), .disp_size(disp_size), .ea_seg(ea_seg),
    .ea_undefined(ea_undefined));

  samd_result_sink samd_result_sink_i (.clk(clk), .resetn(resetn),
    .out_valid(out_valid), .locator_used(locator_used),
    .taken_count(taken_count));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic drive(samd_tb_row_s r, logic impl, logic v);
    in_valid <= v;
    implied_form <= impl;
    locator_byte <= r.loc;
    scaled_index_byte <= r.sib;
    {width_select, mid_is_register, code_seg_default} <= r.ctl[4:2];
    {opsize_override, addrsize_override} <= r.ctl[1:0];
    seg_field_kind <= r.kind;
    seg_field <= r.seg;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 2000) begin
      err_count++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    err_count = 0;
    checked = 0;
    cycle_count = 0;
    resetn = 1'b0;
    drive(rows[0], 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    #1;
    check(32'({out_valid, seg_valid, base_valid, reg_operand}), 32'h0);
    check(32'(ea_seg), 32'h3);
    @(posedge clk);
    in_valid <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    $display("test reset done");
    // Rows back to back, each checked one edge after it is taken
    for (int k = 0; k <= N; k++) begin
      @(posedge clk);
      if (k < N) drive(rows[k], 1'b0, 1'b1);
      else in_valid <= 1'b0;
      #1;
      if (k > 0) begin
        t = rows[k-1];
        check(32'(out_valid), 32'h1);
        check(32'({data32, addr32}), 32'({t.ctl[2] ^ t.ctl[1],
          t.ctl[2] ^ t.ctl[0]}));
        check(32'({locator_used, sib_expected}),
          32'({1'b1, t.sibx}));
        check(32'({seg_valid, seg_valid ? seg_id : 3'h0, invalid_op}),
          32'({t.segv, t.segid, t.inv}));
        check(32'({mid_reg_valid, opcode_ext_valid, mid_bits}),
          32'({t.ctl[3], ~t.ctl[3], t.loc[5:3]}));
        check(32'(reg_operand), 32'(t.regop));
        if (t.regop) begin
          check(32'({op_reg_num, op_reg_high, op_size}),
            32'({t.rnum, t.rhi, t.rsz}));
        end else begin
          check(32'({base_valid, base_valid ? base_reg : 3'h0,
            index_valid, index_valid ? index_reg : 3'h0, scale_bits,
            disp_size, ea_seg}), 32'({t.bv, t.b, t.iv, t.i, t.sc,
            t.disp, t.eseg}));
        end
      end
    end
    $display("test rows done");
    // Inputs change while idle: results hold, no new answer
    @(posedge clk);
    drive(rows[0], 1'b0, 1'b0);
    @(posedge clk);
    #1;
    check(32'({out_valid, reg_operand, op_reg_num, op_reg_high}),
      32'h11);
    check(32'(taken_count), 32'(N));
    $display("test hold done");
    // Implied form then undefined index, back to back
    t = rows[11];
    t.sib = 8'h64;
    @(posedge clk);
    drive(rows[9], 1'b1, 1'b1);
    @(posedge clk);
    drive(t, 1'b0, 1'b1);
    #1;
    check(32'({locator_used, sib_expected, mid_bits}), 32'h0);
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    check(32'({ea_undefined, index_valid}), 32'h2);
    $display("test implied and index done");
    // Reset in mid-run with a request pending
    @(posedge clk);
    in_valid <= 1'b0;
    resetn <= 1'b1;
    #1;
    check(32'({out_valid, base_valid, ea_undefined}), 32'h0);
    check(32'({ea_seg, taken_count}), 32'h30000);
    // First edges after release: idle, then a request is taken
    @(posedge clk);
    drive(rows[4], 1'b0, 1'b1);
    #1;
    check(32'({out_valid, seg_valid, ea_seg}), 32'h3);
    @(posedge clk);
    #1;
    check(32'({out_valid, seg_valid, seg_id}), 32'h1c);
    $display("test second reset done");
    print_verdict();
  end
endmodule
